/* pkg/sst_pkg.sv */
// shared constants and types for the scan test port and its controller
package sst_pkg;
    // widths of the scan registers
    localparam int CELLS = 20;
    localparam int INS_W = 8;
    localparam int CTL_W = 3;
    // instruction codes; only capture and bypass are fixed values
    localparam logic [7:0] INS_CAPTURE = 8'h81;
    localparam logic [7:0] INS_BYPASS = 8'hff;
    localparam logic [7:0] INS_RUN_TEST = 8'h0a;
    localparam logic [7:0] INS_CTL_SCAN = 8'h0e;
    localparam logic [7:0] INS_CHAIN_READ = 8'h07;
    // boundary-control opcodes for the combined modes
    localparam logic [2:0] OP_SIG_RANDOM = 3'h3;
    localparam logic [2:0] OP_SIG_COUNT = 3'h7;
    // feedback taps, one set per data-flow direction
    localparam logic [19:0] SIG_TAPS_AB = 20'h90000;
    localparam logic [19:0] SIG_TAPS_BA = 20'h90000;
    localparam logic [19:0] PAT_TAPS_AB = 20'h90000;
    localparam logic [19:0] PAT_TAPS_BA = 20'h90000;
    // test-clock timing made by the controller
    localparam int CLK_PERIOD_NS = 10;
    localparam int TCK_HALF_NS = 80;
    localparam int TCK_HALF_CYC =
        (TCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TCK_HALF_MIN = 8;
    // controller register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_TMS = 8'h04;
    localparam logic [7:0] REG_TDI = 8'h08;
    localparam logic [7:0] REG_TDO = 8'h0c;
    localparam logic [7:0] REG_STATUS = 8'h10;
    // control register fields
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_LEN_LSB = 8;
    localparam int MAX_BITS = 32;
    localparam logic [5:0] LEN_RESET = 6'h00;
    // tap controller states
    typedef enum logic [15:0] {
        TAP_RESET = 16'h0001,
        TAP_IDLE = 16'h0002,
        TAP_SEL_DR = 16'h0004,
        TAP_CAP_DR = 16'h0008,
        TAP_SH_DR = 16'h0010,
        TAP_EX1_DR = 16'h0020,
        TAP_PAU_DR = 16'h0040,
        TAP_EX2_DR = 16'h0080,
        TAP_UPD_DR = 16'h0100,
        TAP_SEL_IR = 16'h0200,
        TAP_CAP_IR = 16'h0400,
        TAP_SH_IR = 16'h0800,
        TAP_EX1_IR = 16'h1000,
        TAP_PAU_IR = 16'h2000,
        TAP_EX2_IR = 16'h4000,
        TAP_UPD_IR = 16'h8000
    } sst_tap_e;
    // controller sequencer states
    typedef enum logic [2:0] {
        ENG_IDLE = 3'h1,
        ENG_LOW = 3'h2,
        ENG_HIGH = 3'h4
    } sst_eng_e;
endpackage : sst_pkg

/* pkg/sst_if.sv */
// four-wire test access link between controller and device
`timescale 1ns/1ps
interface sst_if;
    logic tck; // test clock from the controller
    logic tms; // mode select
    logic tdi; // serial data into the device
    logic tdo_o; // device serial data out
    logic tdo_oe_n; // low while the device drives tdo
    logic tdo; // resolved wire, pulled high when released
    assign tdo = tdo_oe_n ? 1'b1 : tdo_o;
    modport ctl (output tck, output tms, output tdi, input tdo);
    modport dev (input tck, input tms, input tdi,
        output tdo_o, output tdo_oe_n);
endinterface : sst_if

/* hw/sst_device.sv */
// scan test device: tap, instruction reg, signature and pattern cells
//
// Our own choices: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module sst_device (
    // clock, reset and enable
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // test access link
    sst_if.dev tap_if,
    // normal-function pins
    input wire logic [sst_pkg::CELLS-1:0] pin_in,
    input wire logic a_to_b_output_enable_n,
    input wire logic b_to_a_output_enable_n,
    output logic [sst_pkg::CELLS-1:0] pin_out,
    output logic pin_out_oe_n
);
    import sst_pkg::*;

    // all state of the device in one record
    typedef struct packed {
        logic tck_s1; // synchroniser stages
        logic tck_s2;
        logic tck_d; // previous synced clock, for edges
        logic tms_s1;
        logic tms_s2;
        logic tdi_s1;
        logic tdi_s2;
        logic ab_s1;
        logic ab_s2;
        logic ba_s1;
        logic ba_s2;
        logic [CELLS-1:0] pin_s1;
        logic [CELLS-1:0] pin_s2;
        sst_tap_e tap; // tap controller state
        logic [INS_W-1:0] ins; // active instruction
        logic [INS_W-1:0] ins_sh; // instruction shift stage
        logic [CTL_W-1:0] ctl_op; // boundary_control_reg
        logic byp; // one-bit bypass register
        logic [2*CELLS-1:0] chain; // boundary_chain, inputs low
        logic [CELLS-1:0] shadow; // shadow latches of output cells
        logic tdo; // serial output flop
        logic tdo_oe_n; // serial output enable
        logic pin_oe_n; // output pin enable
    } sst_dev_s;

    sst_dev_s s_r; // registered state
    sst_dev_s s_nxt; // next state
    logic rise; // synced test clock rose
    logic fall; // synced test clock fell
    logic dir_ok; // exactly one direction enabled
    logic sel_op; // control register in the scan path
    logic sel_chain; // boundary chain in the scan path
    logic run; // combined test mode running this cycle
    logic dr_lsb; // bit the selected data register offers
    logic [CELLS-1:0] sig; // signature half of the chain
    logic [CELLS-1:0] pat; // pattern half of the chain
    logic [CELLS-1:0] sig_taps; // signature feedback mask
    logic [CELLS-1:0] pat_taps; // pattern feedback mask

    // standard sixteen-state tap walk on one mode bit
    function automatic sst_tap_e tap_step(input sst_tap_e st,
                                          input logic m);
        case (st)
            TAP_RESET: tap_step = m ? TAP_RESET : TAP_IDLE;
            TAP_IDLE: tap_step = m ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: tap_step = m ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: tap_step = m ? TAP_EX1_DR : TAP_SH_DR;
            TAP_SH_DR: tap_step = m ? TAP_EX1_DR : TAP_SH_DR;
            TAP_EX1_DR: tap_step = m ? TAP_UPD_DR : TAP_PAU_DR;
            TAP_PAU_DR: tap_step = m ? TAP_EX2_DR : TAP_PAU_DR;
            TAP_EX2_DR: tap_step = m ? TAP_UPD_DR : TAP_SH_DR;
            TAP_UPD_DR: tap_step = m ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR: tap_step = m ? TAP_RESET : TAP_CAP_IR;
            TAP_CAP_IR: tap_step = m ? TAP_EX1_IR : TAP_SH_IR;
            TAP_SH_IR: tap_step = m ? TAP_EX1_IR : TAP_SH_IR;
            TAP_EX1_IR: tap_step = m ? TAP_UPD_IR : TAP_PAU_IR;
            TAP_PAU_IR: tap_step = m ? TAP_EX2_IR : TAP_PAU_IR;
            TAP_EX2_IR: tap_step = m ? TAP_UPD_IR : TAP_SH_IR;
            TAP_UPD_IR: tap_step = m ? TAP_SEL_DR : TAP_IDLE;
            default: tap_step = TAP_RESET;
        endcase
    endfunction : tap_step

    // next-state logic for the whole device
    always_comb begin
        s_nxt = s_r;
        // two flops on every input from the link or the board
        s_nxt.tck_s1 = tap_if.tck;
        s_nxt.tck_s2 = s_r.tck_s1;
        s_nxt.tck_d = s_r.tck_s2;
        s_nxt.tms_s1 = tap_if.tms;
        s_nxt.tms_s2 = s_r.tms_s1;
        s_nxt.tdi_s1 = tap_if.tdi;
        s_nxt.tdi_s2 = s_r.tdi_s1;
        s_nxt.ab_s1 = a_to_b_output_enable_n;
        s_nxt.ab_s2 = s_r.ab_s1;
        s_nxt.ba_s1 = b_to_a_output_enable_n;
        s_nxt.ba_s2 = s_r.ba_s1;
        s_nxt.pin_s1 = pin_in;
        s_nxt.pin_s2 = s_r.pin_s1;
        // tms, tdi and clock share the same delay, so they stay aligned
        rise = s_r.tck_s2 & ~s_r.tck_d;
        fall = ~s_r.tck_s2 & s_r.tck_d;
        // equal enables mean no single flow: fall back to bypass
        dir_ok = s_r.ab_s2 ^ s_r.ba_s2;
        sel_op = (s_r.ins == INS_CTL_SCAN);
        sel_chain = (s_r.ins == INS_CHAIN_READ);
        run = (s_r.tap == TAP_IDLE) && (s_r.ins == INS_RUN_TEST) &&
              dir_ok && ((s_r.ctl_op == OP_SIG_RANDOM) ||
              (s_r.ctl_op == OP_SIG_COUNT));
        // a-to-b flow when its enable is low
        sig_taps = s_r.ab_s2 ? SIG_TAPS_BA : SIG_TAPS_AB;
        pat_taps = s_r.ab_s2 ? PAT_TAPS_BA : PAT_TAPS_AB;
        sig = s_r.chain[CELLS-1:0];
        pat = s_r.chain[2*CELLS-1:CELLS];
        // unknown instructions fall through to the bypass bit
        if (sel_op) begin
            dr_lsb = s_r.ctl_op[0];
        end else if (sel_chain) begin
            dr_lsb = s_r.chain[0];
        end else begin
            dr_lsb = s_r.byp;
        end
        // rising test-clock edge: sample, shift, step the tap
        if (rise) begin
            case (s_r.tap)
                TAP_CAP_IR: begin
                    s_nxt.ins_sh = INS_CAPTURE;
                end
                TAP_SH_IR: begin
                    s_nxt.ins_sh = {s_r.tdi_s2,
                                    s_r.ins_sh[INS_W-1:1]};
                end
                TAP_CAP_DR: begin
                    // control reg and chain keep their value here
                    if (!sel_op && !sel_chain) begin
                        s_nxt.byp = 1'b0;
                    end
                end
                TAP_SH_DR: begin
                    if (sel_op) begin
                        s_nxt.ctl_op = {s_r.tdi_s2,
                                        s_r.ctl_op[CTL_W-1:1]};
                    end else if (sel_chain) begin
                        s_nxt.chain = {s_r.tdi_s2,
                                       s_r.chain[2*CELLS-1:1]};
                    end else begin
                        s_nxt.byp = s_r.tdi_s2;
                    end
                end
                TAP_IDLE: begin
                    if (run) begin
                        // signature: shift with feedback, xor pins in
                        s_nxt.chain[CELLS-1:0] =
                            {sig[CELLS-2:0], ^(sig & sig_taps)} ^
                            s_r.pin_s2;
                        if (s_r.ctl_op == OP_SIG_RANDOM) begin
                            // zero seed feeds back zero and stays put
                            s_nxt.chain[2*CELLS-1:CELLS] =
                                {pat[CELLS-2:0],
                                 ^(pat & pat_taps)};
                        end else begin
                            s_nxt.chain[2*CELLS-1:CELLS] =
                                pat + 20'h00001;
                        end
                    end
                end
                default: begin
                end
            endcase
            s_nxt.tap = tap_step(s_r.tap, s_r.tms_s2);
        end
        // falling edge: every pin-facing output moves only here
        if (fall) begin
            s_nxt.tdo_oe_n = !((s_r.tap == TAP_SH_IR) ||
                               (s_r.tap == TAP_SH_DR));
            if (s_r.tap == TAP_SH_IR) begin
                s_nxt.tdo = s_r.ins_sh[0];
            end else begin
                s_nxt.tdo = dr_lsb;
            end
            if (s_r.tap == TAP_UPD_IR) begin
                s_nxt.ins = s_r.ins_sh;
            end else if (s_r.tap == TAP_RESET) begin
                s_nxt.ins = INS_BYPASS;
            end
            if (run) begin
                s_nxt.shadow = pat;
            end
            s_nxt.pin_oe_n = !run;
        end
    end

    // single register stage; enable low freezes everything
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_r <= '0;
            s_r.tap <= TAP_RESET;
            s_r.ins <= INS_BYPASS;
            s_r.tdo_oe_n <= 1'b1;
            s_r.pin_oe_n <= 1'b1;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from flops
    assign tap_if.tdo_o = s_r.tdo;
    assign tap_if.tdo_oe_n = s_r.tdo_oe_n;
    assign pin_out = s_r.shadow;
    assign pin_out_oe_n = s_r.pin_oe_n;
endmodule : sst_device

/* hw/sst_ctrl.sv */
// test controller: ahb-lite registers drive a tms/tdi bit sequencer
`timescale 1ns/1ps
module sst_ctrl #(
    parameter int TCK_HALF = sst_pkg::TCK_HALF_CYC // half test period
) (
    // clock, reset and enable
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // test access link
    sst_if.ctl tap_if
);
    import sst_pkg::*;

    // tdo must settle through both sync stages before sampling
    if (TCK_HALF < TCK_HALF_MIN || TCK_HALF > 65535) begin : g_chk
        $error("TCK_HALF out of range");
    end

    // all state of the controller in one record
    typedef struct packed {
        logic tdo_s1; // tdo synchroniser
        logic tdo_s2;
        logic ph_act; // data phase pending
        logic ph_wr;
        logic [7:0] ph_addr;
        logic rdy; // hreadyout flop
        logic resp; // hresp flop, always okay
        logic [31:0] rdata;
        logic [5:0] len; // bits per sequence
        logic [31:0] tms_v;
        logic [31:0] tdi_v;
        logic [31:0] tdo_v;
        logic [4:0] idx; // current bit
        logic [15:0] cnt; // half-period counter
        sst_eng_e st;
        logic tck;
        logic tms;
        logic tdi;
    } sst_ctl_s;

    sst_ctl_s s_r; // registered state
    sst_ctl_s s_nxt; // next state
    logic take; // address phase accepted
    logic half_done; // half period elapsed
    logic [4:0] idx_n; // next bit index
    logic [5:0] wlen; // written length field

    // next-state logic
    always_comb begin
        s_nxt = s_r;
        s_nxt.tdo_s1 = tap_if.tdo;
        s_nxt.tdo_s2 = s_r.tdo_s1;
        take = hsel & hready & htrans[1];
        half_done = (s_r.cnt == 16'(TCK_HALF - 1));
        idx_n = s_r.idx + 5'd1;
        wlen = hwdata[CTRL_LEN_LSB +: 6];
        // write data phase: zero wait states
        if (s_r.ph_act && s_r.ph_wr) begin
            s_nxt.ph_act = 1'b0;
            case (s_r.ph_addr)
                REG_CTRL: begin
                    // start only when idle and length in range
                    if (s_r.st == ENG_IDLE) begin
                        s_nxt.len = wlen;
                        if (hwdata[CTRL_START_BIT] && wlen != 6'd0 &&
                            wlen <= 6'(MAX_BITS)) begin
                            s_nxt.st = ENG_LOW;
                            s_nxt.idx = 5'd0;
                            s_nxt.cnt = 16'd0;
                            s_nxt.tdo_v = 32'h0;
                            s_nxt.tms = s_r.tms_v[0];
                            s_nxt.tdi = s_r.tdi_v[0];
                        end
                    end
                end
                REG_TMS: begin
                    if (s_r.st == ENG_IDLE) begin
                        s_nxt.tms_v = hwdata;
                    end
                end
                REG_TDI: begin
                    if (s_r.st == ENG_IDLE) begin
                        s_nxt.tdi_v = hwdata;
                    end
                end
                default: begin
                end
            endcase
        end
        // read data phase: one wait state, data from settled state
        if (s_r.ph_act && !s_r.ph_wr) begin
            s_nxt.ph_act = 1'b0;
            s_nxt.rdy = 1'b1;
            case (s_r.ph_addr)
                REG_CTRL: s_nxt.rdata = {18'h0, s_r.len, 8'h0};
                REG_TMS: s_nxt.rdata = s_r.tms_v;
                REG_TDI: s_nxt.rdata = s_r.tdi_v;
                REG_TDO: s_nxt.rdata = s_r.tdo_v;
                REG_STATUS: s_nxt.rdata = {31'h0, s_r.st != ENG_IDLE};
                default: s_nxt.rdata = 32'h0;
            endcase
        end
        if (take) begin
            s_nxt.ph_act = 1'b1;
            s_nxt.ph_wr = hwrite;
            s_nxt.ph_addr = haddr[7:0];
            s_nxt.rdy = hwrite;
        end
        // bit sequencer: tms and tdi move at the start write and as tck falls
        case (s_r.st)
            ENG_IDLE: begin
            end
            ENG_LOW: begin
                s_nxt.cnt = s_r.cnt + 16'd1;
                if (half_done) begin
                    s_nxt.cnt = 16'd0;
                    s_nxt.tck = 1'b1;
                    s_nxt.tdo_v[s_r.idx] = s_r.tdo_s2;
                    s_nxt.st = ENG_HIGH;
                end
            end
            ENG_HIGH: begin
                s_nxt.cnt = s_r.cnt + 16'd1;
                if (half_done) begin
                    s_nxt.cnt = 16'd0;
                    s_nxt.tck = 1'b0;
                    if ({1'b0, s_r.idx} == s_r.len - 6'd1) begin
                        s_nxt.st = ENG_IDLE;
                    end else begin
                        s_nxt.idx = idx_n;
                        s_nxt.tms = s_r.tms_v[idx_n];
                        s_nxt.tdi = s_r.tdi_v[idx_n];
                        s_nxt.st = ENG_LOW;
                    end
                end
            end
            default: begin
                s_nxt.st = ENG_IDLE;
            end
        endcase
    end

    // single register stage; enable low freezes everything
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_r <= '0;
            s_r.st <= ENG_IDLE;
            s_r.rdy <= 1'b1;
            s_r.len <= LEN_RESET;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from flops
    assign hrdata = s_r.rdata;
    assign hreadyout = s_r.rdy;
    assign hresp = s_r.resp;
    assign tap_if.tck = s_r.tck;
    assign tap_if.tms = s_r.tms;
    assign tap_if.tdi = s_r.tdi;
endmodule : sst_ctrl

/* verification/sst_link_assertions.sv */
// concurrent checks on the four-wire test link between the two ends
`timescale 1ns/1ps
module sst_link_assertions (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // link wires
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic tdo_o,
    input wire logic tdo_oe_n
);
    // one domain, so clock and reset are shared by every check
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // high phases of the test clock are exactly eight system clocks, low phases at least eight
    chk_tck_high_len: assert property ($rose(tck) |-> tck [*8] ##1 !tck)
        else $error("test clock high phase has the wrong length");
    chk_tck_low_len: assert property ($fell(tck) |-> (!tck) [*8])
        else $error("test clock low phase too short");
    // controller moves its bits only while the clock is low
    chk_tms_on_fall: assert property (($changed(tms) || $changed(tdi)) |-> !tck)
        else $error("tms or tdi moved while the test clock was high");
    chk_bits_hold_high: assert property (tck |-> $stable(tms) && $stable(tdi))
        else $error("tms or tdi not steady across the rising edge");
    // device output moves a few clocks after a fall, never near a rise
    chk_tdo_hold_high: assert property (tck |-> $stable(tdo_o) && $stable(tdo_oe_n))
        else $error("tdo moved while the test clock was high");
    chk_tdo_fall_lag: assert property (($changed(tdo_o) || $changed(tdo_oe_n))
        |-> !$past(tck, 3) && $past(tck, 6))
        else $error("tdo moved away from a falling edge");
    // tms at the rise before the change tells shift entry from exit
    chk_drive_in_shift: assert property ($fell(tdo_oe_n) |-> !$past(tms, 6))
        else $error("tdo driven without entering a shift state");
    chk_release_exit: assert property ($rose(tdo_oe_n) |-> $past(tms, 6))
        else $error("tdo released without moving to exit1");
endmodule : sst_link_assertions

/* verification/scan_signature_pattern_test_test.sv */
// self-checking bench: controller and device joined on one link
`timescale 1ns/1ps
module scan_signature_pattern_test_test;
    import sst_pkg::*;
    logic hclk = 1'b0; // system clock
    logic hresetn = 1'b0; // active-low reset
    logic hsel = 1'b0; // bus drive, all changed after a rise
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [CELLS-1:0] pin_in = 20'h5a3c1; // steady input-side pattern
    logic a_to_b_output_enable_n = 1'b0; // one direction enabled
    logic b_to_a_output_enable_n = 1'b1;
    logic [CELLS-1:0] pin_out;
    logic pin_out_oe_n;
    logic [20:0] smp [6]; // {oe_n, pins} seen at test-clock rises
    int failures = 0;
    int checked = 0;
    sst_if link ();
    always #5 hclk = ~hclk;
    sst_ctrl sst_ctrl_i (.hclk(hclk), .hresetn(hresetn), .ce(1'b1),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .tap_if(link.ctl));
    sst_device sst_device_i (.hclk(hclk), .hresetn(hresetn), .ce(1'b1),
        .tap_if(link.dev), .pin_in(pin_in),
        .a_to_b_output_enable_n(a_to_b_output_enable_n),
        .b_to_a_output_enable_n(b_to_a_output_enable_n),
        .pin_out(pin_out), .pin_out_oe_n(pin_out_oe_n));
    sst_link_assertions sst_link_assertions_i (.hclk(hclk),
        .hresetn(hresetn), .tck(link.tck), .tms(link.tms), .tdi(link.tdi),
        .tdo_o(link.tdo_o), .tdo_oe_n(link.tdo_oe_n));
    // compare and count; an unknown bit matches only an unknown bit
    task check(input string what, input logic [31:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task report_and_stop;
        $display("checks %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : report_and_stop
    // one single ahb-lite transfer; entered just after a rising edge
    task bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask : bus
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask : wr
    task rd(input logic [7:0] a, output logic [31:0] d);
        bus(1'b0, a, 32'h0, d);
    endtask : rd
    // run n link cycles, optionally sampling the pins at six rises
    task scan(input int n, input logic [31:0] m, i, input bit w,
        output logic [31:0] o);
        logic [31:0] s;
        wr(REG_TMS, m);
        wr(REG_TDI, i);
        wr(REG_CTRL, (32'(n) << CTRL_LEN_LSB) | 32'h1);
        if (w) begin
            for (int k = 0; k < 6; k++) begin
                @(posedge link.tck);
                smp[k] = {pin_out_oe_n, pin_out};
            end
        end
        s = 32'h1;
        for (int k = 0; k < 400 && s[0] !== 1'b0; k++) rd(REG_STATUS, s);
        check("busy", s, 32'h0);
        rd(REG_TDO, o);
    endtask : scan
    // instruction scan from idle back to idle
    task ins_scan(input logic [7:0] code);
        logic [31:0] t;
        scan(14, 32'h1803, {20'h0, code, 4'h0}, 1'b0, t);
        check("instr out", t[13:0], {2'b11, INS_CAPTURE, 4'hf});
    endtask : ins_scan
    // data scan of n bits from idle back to idle
    task dr(input int n, input logic [31:0] d, output logic [31:0] o);
        logic [31:0] t;
        scan(n + 5, 32'h1 | (32'h3 << (n + 2)), d << 3, 1'b0, t);
        check("dr idle tdo", t[2:0], 3'h7);
        o = (t >> 3) & ((32'h1 << n) - 1);
    endtask : dr
    // load a boundary-control opcode, start the run, watch the pins
    task mode(input logic [2:0] op);
        logic [31:0] v;
        ins_scan(INS_CTL_SCAN);
        dr(3, {29'h0, op}, v);
        ins_scan(INS_RUN_TEST);
        scan(12, 32'h0, 32'h0, 1'b1, v);
    endtask : mode
    task t_reset;
        logic [31:0] v;
        check("tdo_oe_n", link.tdo_oe_n, 32'h1);
        check("pin_out_oe_n", pin_out_oe_n, 32'h1);
        rd(REG_CTRL, v);
        check("len", v[13:8], LEN_RESET);
        rd(8'h40, v);
        check("unmapped", v, 32'h0);
        wr(REG_TMS, 32'ha5a5_0f0f);
        rd(REG_TMS, v);
        check("tms reg", v, 32'ha5a5_0f0f);
        check("hresp", hresp, 32'h0);
    endtask : t_reset
    // leave reset, load all ones, bypass bit reads zero then tdi
    task t_instr;
        logic [31:0] v;
        scan(1, 32'h0, 32'h0, 1'b0, v);
        ins_scan(INS_BYPASS);
        dr(2, 32'h3, v);
        check("bypass", v, 32'h2);
    endtask : t_instr
    task t_modes;
        logic [31:0] v;
        logic [19:0] s;
        ins_scan(INS_CHAIN_READ);
        // two passes clear both halves, the seed
        dr(20, 32'h0, v);
        dr(20, 32'h0, v);
        mode(OP_SIG_RANDOM);
        for (int k = 0; k < 6; k++) check("zero seed", smp[k], 32'h0);
        s = 20'h0;
        // twelve idle rises, one more as the next scan leaves idle
        repeat (13) s = {s[18:0], ^(s & SIG_TAPS_AB)} ^ pin_in;
        ins_scan(INS_CHAIN_READ);
        dr(20, 32'h0, v);
        check("signature", v, {12'h0, s});
        mode(OP_SIG_COUNT);
        for (int k = 0; k < 6; k++) check("count", smp[k], 20'(k));
        mode(OP_SIG_RANDOM);
        for (int k = 1; k < 6; k++) begin
            check("random step", smp[k] != smp[k-1], 32'h1);
            check("random drive", smp[k][20], 32'h0);
        end
        // both directions on: the run must fall back to bypass
        b_to_a_output_enable_n <= 1'b0;
        scan(12, 32'h0, 32'h0, 1'b1, v);
        for (int k = 2; k < 6; k++) check("no run", smp[k], smp[1]);
        check("no drive", smp[1][20], 32'h1);
    endtask : t_modes
    // main sequence
    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_instr();
        t_modes();
        report_and_stop();
    end
    // watchdog, well beyond the expected run length
    initial begin
        repeat (60000) @(posedge hclk);
        failures++;
        report_and_stop();
    end
endmodule : scan_signature_pattern_test_test
